/* File: rtl/arf_map.svh */
// constants for the alu result forwarding path
`ifndef ARF_MAP_SVH
`define ARF_MAP_SVH
`define ARF_MCK_ALU1_BIT 0
`define ARF_MCK_ALU2_BIT 1
`define ARF_WORD_RST 32'h0000_0000
`define ARF_MASK_RST 4'h0
`define ARF_STAT_RST 8'h00
`define ARF_ADDR_RST 8'h00
`define ARF_MCK_RST 2'h0
`define ARF_ERR_RST 4'h0
`endif

/* File: rtl/arf_pkg.sv */
// types for the alu result forwarding path
package arf_pkg;
   typedef enum logic [1:0] {
      ARF_OP_BYTE,
      ARF_OP_WORD_P1,
      ARF_OP_WORD_P2,
      ARF_OP_NONE
   } arf_op_t;
endpackage : arf_pkg

/* File: rtl/arf_byte_merge.sv */
// per-byte merge of forwarded result over local-storage data
`timescale 1ns/1ps
module arf_byte_merge (
   // select and data
   input wire logic [3:0] sel,
   input wire logic [31:0] fwd,
   input wire logic [31:0] ls,
   output logic [31:0] merged
);
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_byte
         assign merged[8*i +: 8] = sel[i] ? fwd[8*i +: 8] : ls[8*i +: 8];
      end
   endgenerate
endmodule : arf_byte_merge

/* File: rtl/arf_result_path.sv */
// alu result register, fast paths, destination and bypass
`timescale 1ns/1ps
`include "arf_map.svh"
module arf_result_path (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control word strobe and op
   input wire logic cw_step,
   input wire arf_pkg::arf_op_t op,
   input wire logic decimal_op,
   input wire logic [1:0] byte_sel,
   // alu entry check inputs
   input wire logic [7:0] half_sum1,
   input wire logic [7:0] half_sum2,
   input wire logic [1:0] par1,
   input wire logic [1:0] par2,
   // alu results
   input wire logic [7:0] alu1_res,
   input wire logic [7:0] alu2_res,
   // status test request
   input wire logic test_en,
   input wire logic [7:0] test_mask,
   input wire logic test_set,
   // destination kind of this word
   input wire logic dest_fast,
   input wire logic [1:0] fast_sel,
   input wire logic dest_ls,
   input wire logic [7:0] dest_addr,
   // next word source addresses
   input wire logic [7:0] src_a_addr,
   input wire logic src_a_ls,
   input wire logic [7:0] src_b_addr,
   input wire logic src_b_ls,
   input wire logic [31:0] ls_a_data,
   input wire logic [31:0] ls_b_data,
   // outputs
   output logic [31:0] result_r,
   output logic [3:0] altered_r,
   output logic [7:0] status_r,
   output logic [31:0] fast_reg_r [3],
   output logic [31:0] opnd_a,
   output logic [31:0] opnd_b,
   output logic [31:0] dest_r,
   output logic [3:0] dest_mask_r,
   output logic dest_to_ls_r,
   output logic [7:0] dest_addr_r,
   output logic [1:0] mck_alu_r,
   output logic [3:0] entry_err_r
);
   logic pend_ls_r;
   logic [7:0] pend_addr_r;
   logic err1;
   logic err2;
   logic [31:0] res_nxt;
   logic [3:0] alt_nxt;
   logic [3:0] fwd_a_sel;
   logic [3:0] fwd_b_sel;
   logic [1:0] pass_ix;

   // odd count of half-sums must match the two parity bits' odd sum
   function automatic logic hs_err(input logic [7:0] hs,
                                   input logic [1:0] p);
      hs_err = (^hs) != (p[0] ^ p[1]);
   endfunction : hs_err

   assign err1 = cw_step && op != arf_pkg::ARF_OP_NONE && !decimal_op
      && hs_err(half_sum1, par1);
   assign err2 = cw_step && op != arf_pkg::ARF_OP_NONE
      && hs_err(half_sum2, par2);
   assign pass_ix = (op == arf_pkg::ARF_OP_WORD_P2) ? 2'h2 : 2'h0;

   // latch bits: [0] alu1 p1, [1] alu2 p1, [2] alu1 p2, [3] alu2 p2
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         entry_err_r <= `ARF_ERR_RST;
      end else if (cw_step) begin
         entry_err_r[pass_ix] <= err1;
         entry_err_r[pass_ix + 2'h1] <= err2;
      end
   end

   // sticky: only reset clears
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mck_alu_r <= `ARF_MCK_RST;
      end else begin
         if (err1) mck_alu_r[`ARF_MCK_ALU1_BIT] <= 1'b1;
         if (err2) mck_alu_r[`ARF_MCK_ALU2_BIT] <= 1'b1;
      end
   end

   always_comb begin
      res_nxt = result_r;
      alt_nxt = 4'h0;
      unique case (op)
         arf_pkg::ARF_OP_BYTE: begin
            res_nxt = {4{alu2_res}};
            alt_nxt = 4'h1 << byte_sel;
         end
         arf_pkg::ARF_OP_WORD_P1: begin
            res_nxt = {alu2_res, alu1_res, alu2_res, alu1_res};
            alt_nxt = 4'hF;
         end
         arf_pkg::ARF_OP_WORD_P2: begin
            res_nxt = {result_r[31:16], alu2_res, alu1_res};
            alt_nxt = 4'hF;
         end
         arf_pkg::ARF_OP_NONE: begin
            res_nxt = result_r;
            alt_nxt = 4'h0;
         end
      endcase
   end

   // byte numbering: byte 0 in bits 7:0
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_r <= `ARF_WORD_RST;
         altered_r <= `ARF_MASK_RST;
      end else if (cw_step) begin
         result_r <= res_nxt;
         altered_r <= alt_nxt;
      end
   end

   // fast externals see the result at once, usable by the next word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= `ARF_STAT_RST;
         for (int i = 0; i < 3; i++) fast_reg_r[i] <= `ARF_WORD_RST;
      end else if (cw_step) begin
         if (dest_fast && fast_sel == 2'h0)
            status_r <= res_nxt[7:0];
         else if (dest_fast)
            fast_reg_r[fast_sel - 2'h1] <= res_nxt;
         if (test_en && test_set && res_nxt != 32'h0)
            status_r <= status_r | test_mask;
         else if (test_en && res_nxt == 32'h0)
            status_r <= status_r & ~test_mask;
      end
   end

   // slow destinations written one cycle later; no bypass for externals
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dest_r <= `ARF_WORD_RST;
         dest_mask_r <= `ARF_MASK_RST;
         dest_to_ls_r <= 1'b0;
         dest_addr_r <= `ARF_ADDR_RST;
         pend_ls_r <= 1'b0;
         pend_addr_r <= `ARF_ADDR_RST;
      end else if (cw_step) begin
         dest_r <= result_r;
         dest_mask_r <= pend_ls_r ? altered_r : 4'h0;
         dest_to_ls_r <= pend_ls_r;
         dest_addr_r <= pend_addr_r;
         pend_ls_r <= dest_ls && !dest_fast && op != arf_pkg::ARF_OP_NONE;
         pend_addr_r <= dest_addr;
      end
   end

   assign fwd_a_sel = (src_a_ls && pend_ls_r && src_a_addr == pend_addr_r)
      ? altered_r : 4'h0;
   assign fwd_b_sel = (src_b_ls && pend_ls_r && src_b_addr == pend_addr_r)
      ? altered_r : 4'h0;

   arf_byte_merge u_merge_a (
      .sel(fwd_a_sel),
      .fwd(result_r),
      .ls(ls_a_data),
      .merged(opnd_a)
   );
   arf_byte_merge u_merge_b (
      .sel(fwd_b_sel),
      .fwd(result_r),
      .ls(ls_b_data),
      .merged(opnd_b)
   );

   mck_sticky_a: assert property (
      @(posedge clk) disable iff (rst) err1 |=> mck_alu_r[0])
      else $error("alu1 check not set");
   byte_repl_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step && op == arf_pkg::ARF_OP_BYTE |=>
      result_r == {4{result_r[7:0]}}) else $error("byte not replicated");
   dest_follow_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step |=> dest_r == $past(result_r)) else $error("dest stale");
   fwd_byte_a: assert property (
      @(posedge clk) disable iff (rst)
      fwd_a_sel == 4'h0 |-> opnd_a == ls_a_data)
      else $error("unexpected forward");
   dec_block_a: assert property (
      @(posedge clk) disable iff (rst) decimal_op |-> !err1)
      else $error("decimal check not blocked");
   alt_mask_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step && op == arf_pkg::ARF_OP_WORD_P1 |=> altered_r == 4'hF)
      else $error("mask wrong");
   fast_path_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step && dest_fast && fast_sel == 2'h1 |=>
      fast_reg_r[0] == result_r) else $error("fast path late");
   word_p2_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step && op == arf_pkg::ARF_OP_WORD_P2 |=>
      result_r[31:16] == $past(result_r[31:16]))
      else $error("upper bytes changed");
   // first-pass latch of the first alu must stay clear in decimal ops
   dec_latch_a: assert property (
      @(posedge clk) disable iff (rst)
      cw_step && decimal_op && op != arf_pkg::ARF_OP_WORD_P2 |=>
      !entry_err_r[0]) else $error("decimal latch set");
   fwd_full_a: assert property (
      @(posedge clk) disable iff (rst)
      src_a_ls && pend_ls_r && src_a_addr == pend_addr_r &&
      altered_r == 4'hF |-> opnd_a == result_r)
      else $error("forward missed");
endmodule : arf_result_path

/* File: dv/arf_ls_model.sv */
// local storage model on the far side of the result path
`timescale 1ns/1ps
module arf_ls_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write side from the destination register
   input wire logic cw_step,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_mask,
   // read side
   input wire logic [7:0] addr_a,
   input wire logic [7:0] addr_b,
   output logic [31:0] rd_a,
   output logic [31:0] rd_b
);
   logic [31:0] mem_r [256];
   // write lands at the end of the destination cycle, so the word
   // right after the producer still reads the stale location
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 256; i++) mem_r[i] <= {4{i[7:0]}};
      end else if (cw_step && wr_en) begin
         for (int b = 0; b < 4; b++) begin
            if (wr_mask[b]) mem_r[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
         end
      end
   end
   assign rd_a = mem_r[addr_a];
   assign rd_b = mem_r[addr_b];
endmodule : arf_ls_model

/* File: dv/tb.sv */
// self-checking bench for the alu result forwarding path
`timescale 1ns/1ps
module tb;
   logic clk, rst, cw, dec, ten, tset, dfast, dls, sals, sbls, dtl;
   arf_pkg::arf_op_t op;
   logic [1:0] bsel, p1, p2, fsel, mck;
   logic [7:0] h1, h2, a1, a2, tmask, dad, saa, sba, st, dar;
   logic [31:0] lsa, lsb, res, oa, ob, dr;
   logic [31:0] fr [3];
   logic [3:0] alt, dm, ee;
   int n_fail = 0, total_checks = 0, cyc = 0;
   arf_result_path dut (.clk(clk), .rst(rst), .cw_step(cw), .op(op),
      .decimal_op(dec), .byte_sel(bsel), .half_sum1(h1), .half_sum2(h2),
      .par1(p1), .par2(p2), .alu1_res(a1), .alu2_res(a2), .test_en(ten),
      .test_mask(tmask), .test_set(tset), .dest_fast(dfast),
      .fast_sel(fsel), .dest_ls(dls), .dest_addr(dad), .src_a_addr(saa),
      .src_a_ls(sals), .src_b_addr(sba), .src_b_ls(sbls), .ls_a_data(lsa),
      .ls_b_data(lsb), .result_r(res), .altered_r(alt), .status_r(st),
      .fast_reg_r(fr), .opnd_a(oa), .opnd_b(ob), .dest_r(dr),
      .dest_mask_r(dm), .dest_to_ls_r(dtl), .dest_addr_r(dar),
      .mck_alu_r(mck), .entry_err_r(ee));
   arf_ls_model ls (.clk(clk), .rst(rst), .cw_step(cw), .wr_en(dtl),
      .wr_addr(dar), .wr_data(dr), .wr_mask(dm), .addr_a(saa),
      .addr_b(sba), .rd_a(lsa), .rd_b(lsb));
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         $display("unexpected %s exp %h got %h", nm, e, s);
         n_fail++;
      end
   endtask : chk
   task clr;
      {cw, dec, ten, tset, dfast, dls, sals, sbls, bsel, p1, p2} = '0;
      {fsel, h1, h2, a1, a2, tmask, dad, saa, sba} = '0;
      op = arf_pkg::ARF_OP_NONE;
   endtask : clr
   task idle;
      @(posedge clk);
      #1;
   endtask : idle
   // one idle edge keeps the strobe low between two steps
   task go;
      cw = 1'b1;
      @(posedge clk);
      #1 cw = 1'b0;
      idle;
   endtask : go
   task t_word;
      op = arf_pkg::ARF_OP_WORD_P1; a1 = 8'h11; a2 = 8'h22; go;
      chk("p1", 32'h2211_2211, res);
      chk("p1 alt", 32'h0000_000F, 32'(alt));
      op = arf_pkg::ARF_OP_WORD_P2; a1 = 8'h33; a2 = 8'h44; go;
      chk("p2", 32'h2211_4433, res);
      $display("test word done");
   endtask : t_word
   task t_fwd;
      op = arf_pkg::ARF_OP_WORD_P1; a1 = 8'h11; a2 = 8'h22;
      dls = 1'b1; dad = 8'h05; go;
      saa = 8'h05; sals = 1'b1; sba = 8'h06; sbls = 1'b1; idle;
      chk("opnd_a fwd", 32'h2211_2211, oa);
      chk("opnd_b ls", 32'h0606_0606, ob);
      op = arf_pkg::ARF_OP_BYTE; a2 = 8'hA5; bsel = 2'h2; dad = 8'h07; go;
      chk("dest", 32'h2211_2211, dr);
      chk("dest ctl", 32'h0000_1F05, 32'({dtl, dm, dar}));
      chk("byte", 32'hA5A5_A5A5, res);
      chk("byte alt", 32'h0000_0004, 32'(alt));
      saa = 8'h07; sba = 8'h07; idle;
      chk("opnd_a merge", 32'h07A5_0707, oa);
      chk("opnd_b merge", 32'h07A5_0707, ob);
      saa = 8'h05; op = arf_pkg::ARF_OP_NONE; dls = 1'b0; go;
      chk("ls written", 32'h2211_2211, oa);
      chk("dest byte", 32'h0000_1407, 32'({dtl, dm, dar}));
      $display("test forward done");
   endtask : t_fwd
   task t_fast;
      op = arf_pkg::ARF_OP_BYTE; a2 = 8'h3C; dfast = 1; fsel = 1;
      ten = 1; tset = 1; tmask = 8'h81; go;
      chk("fast", 32'h3C3C_3C3C, fr[0]);
      chk("stat set", 32'h0000_0081, 32'(st));
      a2 = 8'h00; dfast = 0; tmask = 8'h01; go;
      chk("stat clr", 32'h0000_0080, 32'(st));
      a2 = 8'h5A; dfast = 1'b1; fsel = 2'h0; ten = 1'b0; go;
      chk("stat fast", 32'h0000_005A, 32'(st));
      fsel = 2'h3; ten = 1'b1; tset = 1'b0; tmask = 8'hFF; go;
      chk("fast 3", 32'h5A5A_5A5A, fr[2]);
      chk("fast 2", 32'h0000_0000, fr[1]);
      chk("stat kept", 32'h0000_005A, 32'(st));
      $display("test fast done");
   endtask : t_fast
   task t_par;
      op = arf_pkg::ARF_OP_WORD_P1; dec = 1; h1 = 8'h01; h2 = 8'h01; go;
      chk("mck dec", 32'h0000_0002, 32'(mck));
      chk("err dec", 32'h0000_0002, 32'(ee));
      dec = 0; h2 = 8'h03; go;
      chk("mck sticky", 32'h0000_0003, 32'(mck));
      chk("err p1", 32'h0000_0001, 32'(ee));
      op = arf_pkg::ARF_OP_WORD_P2; h1 = 8'h00; h2 = 8'h01; go;
      chk("err p2", 32'h0000_0009, 32'(ee));
      chk("mck kept", 32'h0000_0003, 32'(mck));
      $display("test parity done");
   endtask : t_par
   task t_rst;
      rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      chk("rst res", 32'h0000_0000, res);
      chk("rst mck", 32'h0000_0000, 32'(mck));
      chk("rst err", 32'h0000_0000, 32'(ee));
      $display("test reset done");
   endtask : t_rst
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      rst = 1;
      clr;
      repeat (12) @(posedge clk);
      #1 rst = 0;
      t_word;
      clr;
      t_fwd;
      clr;
      t_fast;
      clr;
      t_par;
      t_rst;
      report_and_stop;
   end
endmodule : tb
